// >>> src/isp_irq_map.sv
// Overview of operation
// - Exactly 32 request lines, numbered from zero, go to the core interrupt controller.
// - Each line has one of four programmable levels, and an enabled mask level blocks lines at or below it.
// - Software picks any one line to drive the non-maskable interrupt output.
// - A peripheral with several flags raises its single line while any of those flags is set; the three port pin flags keep a line each.
// - Lines 0 to 11 carry the twelve wake-up pins in matching order.
// - Line 12 is the two-wire bus, lines 13 to 16 the four timers, line 17 the sync serial port.
// - Line 18 merges all seven flags of the first serial port.
// - The programmed levels rank requests; between equal levels the lower line number wins.
// - Lines 19 to 23 are second serial port, comparators, converter, watchdog and brown-out.
// - Lines 25 to 27 are the port pin interrupts, 29 DMA, 30 real-time clock; 24, 28, 31 reserved.
module isp_irq_map
	import isp_pkg::*;
#(
	parameter int NUM_LINES = ISP_NUM_LINES,
	parameter int NUM_WAKE = ISP_NUM_WAKE
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_clk_en,
	input wire logic [NUM_WAKE-1:0] i_wakeup_pins,
	input wire logic i_twowire_state_flag,
	input wire logic [7:0] i_short_timer_a_flags,
	input wire logic [7:0] i_short_timer_b_flags,
	input wire logic [7:0] i_long_timer_a_flags,
	input wire logic [7:0] i_long_timer_b_flags,
	input wire logic [3:0] i_sync_serial_port_flags,
	input wire logic [6:0] i_serial_port_first_flags,
	input wire logic [5:0] i_serial_port_second_flags,
	input wire logic [1:0] i_comparator_flags,
	input wire logic i_adc_done_flag,
	input wire logic i_watchdog_unit_flag,
	input wire logic i_brownout_detector_flag,
	input wire logic [2:0] i_port_pin_flags,
	input wire logic i_dma_flag,
	input wire logic i_rtc_flag,
	input wire logic [ISP_ADDR_W-1:0] i_addr,
	input wire logic [ISP_DATA_W-1:0] i_wr_data,
	input wire logic i_wr_strobe,
	input wire logic i_rd_strobe,
	output logic [ISP_DATA_W-1:0] o_rd_data,
	output logic [NUM_LINES-1:0] o_irq_lines,
	output logic [NUM_LINES-1:0] o_irq_pending,
	output logic o_top_valid,
	output logic [ISP_ID_W-1:0] o_top_id,
	output logic [ISP_PRIO_W-1:0] o_top_level,
	output logic o_nmi,
	output logic o_irq
);
	// the line map below is fixed, so any other size is refused at elaboration
	if (NUM_LINES != ISP_NUM_LINES || NUM_WAKE != ISP_NUM_WAKE) begin : g_bad_size
		$error("isp_irq_map: the line map serves 32 lines and 12 wake pins only");
	end

	////////////////////////////////////////////////////////////////////////////////
	// merge of peripheral flags

	logic [NUM_LINES-1:0] lines_d;
	logic [NUM_LINES-1:0] lines_q;
	logic [NUM_LINES-1:0] rising;

	assign lines_d[ISP_LINE_WAKE_FIRST +: NUM_WAKE] = i_wakeup_pins;
	assign lines_d[ISP_LINE_TWOWIRE] = i_twowire_state_flag;
	logic [7:0] timer_flags [4];
	assign timer_flags[0] = i_short_timer_a_flags;
	assign timer_flags[1] = i_short_timer_b_flags;
	assign timer_flags[2] = i_long_timer_a_flags;
	assign timer_flags[3] = i_long_timer_b_flags;
	genvar t;
	for (t = 0; t < 4; t++) begin : g_timer
		assign lines_d[ISP_LINE_TIMER_FIRST + t] = |timer_flags[t];
	end
	assign lines_d[ISP_LINE_SYNC_SERIAL] = |i_sync_serial_port_flags;
	assign lines_d[ISP_LINE_SERIAL_FIRST] = |i_serial_port_first_flags;
	assign lines_d[ISP_LINE_SERIAL_SECOND] = |i_serial_port_second_flags;
	assign lines_d[ISP_LINE_COMPARATOR] = |i_comparator_flags;
	assign lines_d[ISP_LINE_ADC] = i_adc_done_flag;
	assign lines_d[ISP_LINE_WATCHDOG] = i_watchdog_unit_flag;
	assign lines_d[ISP_LINE_BROWNOUT] = i_brownout_detector_flag;
	assign lines_d[ISP_LINE_PORT_FIRST +: 3] = i_port_pin_flags;
	assign lines_d[ISP_LINE_DMA] = i_dma_flag;
	assign lines_d[ISP_LINE_RTC] = i_rtc_flag;
	assign lines_d[ISP_LINE_RSVD_A] = 1'b0;
	assign lines_d[ISP_LINE_RSVD_B] = 1'b0;
	assign lines_d[ISP_LINE_RSVD_C] = 1'b0;

	// a line that rises while blocked is recorded, so a masked request is not lost unseen
	assign rising = lines_d & ~lines_q;

	////////////////////////////////////////////////////////////////////////////////
	// register port decode

	logic [ISP_DATA_W-1:0] prio_lo_q;
	logic [ISP_DATA_W-1:0] prio_hi_q;
	logic [2:0] mask_lvl_q;
	logic [5:0] nmi_sel_q;
	logic [ISP_EV_W-1:0] ev_stat_q;
	logic [ISP_EV_W-1:0] ev_stat_d;
	logic [ISP_EV_W-1:0] ev_mask_q;
	logic [ISP_DATA_W-1:0] rd_data_d;

	// writes are ignored while the clock enable is low
	wire wr_en = i_clk_en && i_wr_strobe;
	wire wr_prio_lo = wr_en && (i_addr == ISP_OFS_PRIO_LO);
	wire wr_prio_hi = wr_en && (i_addr == ISP_OFS_PRIO_HI);
	wire wr_mask_lvl = wr_en && (i_addr == ISP_OFS_MASK_LVL);
	wire wr_nmi_sel = wr_en && (i_addr == ISP_OFS_NMI_SEL);
	wire wr_ev_stat = wr_en && (i_addr == ISP_OFS_EV_STAT);
	wire wr_ev_mask = wr_en && (i_addr == ISP_OFS_EV_MASK);

	////////////////////////////////////////////////////////////////////////////////
	// level masking and selection

	wire [NUM_LINES*ISP_PRIO_W-1:0] prio_all = {prio_hi_q, prio_lo_q};
	wire mask_en = mask_lvl_q[ISP_MASK_EN_BIT];
	wire [ISP_PRIO_W-1:0] mask_level = mask_lvl_q[ISP_MASK_LVL_LSB +: ISP_PRIO_W];
	logic [NUM_LINES-1:0] blocked;
	logic [NUM_LINES-1:0] pending_d;
	logic sel_valid;
	logic [ISP_ID_W-1:0] sel_id;
	logic [ISP_PRIO_W-1:0] sel_level;

	// level 0 is the most urgent, so an enabled mask level of 0 blocks every line
	genvar g;
	generate
		for (g = 0; g < NUM_LINES; g++) begin : g_mask
			assign blocked[g] = mask_en && (prio_all[g*ISP_PRIO_W +: ISP_PRIO_W] >= mask_level);
		end
	endgenerate

	// pending keeps only the lines that the mask level lets through
	assign pending_d = lines_d & ~blocked;

	isp_prio_sel #(
		.N(NUM_LINES),
		.PW(ISP_PRIO_W),
		.IW(ISP_ID_W)
	) u_sel (
		.i_req(pending_d),
		.i_prio(prio_all),
		.o_valid(sel_valid),
		.o_id(sel_id),
		.o_level(sel_level)
	);

	// the nmi source bypasses the mask level and uses the raw merged line
	// selectable nmi source
	wire nmi_d = nmi_sel_q[ISP_NMI_EN_BIT] && lines_d[nmi_sel_q[ISP_ID_W-1:0]];
	wire ev_nmi = nmi_d && !o_nmi;
	wire ev_blocked = |(rising & blocked);

	wire [ISP_EV_W-1:0] ev_clear = wr_ev_stat ? i_wr_data[ISP_EV_W-1:0] : ISP_RST_EV;
	wire [ISP_EV_W-1:0] ev_set = {ev_blocked, ev_nmi};

	// set wins over write-one-to-clear, so an event in the clearing cycle is kept
	assign ev_stat_d = (ev_stat_q & ~ev_clear) | ev_set;

	// a spare bit sits between the level field and the valid flag
	wire [ISP_DATA_W-1:0] top_word = {{(ISP_DATA_W - ISP_TOP_VALID_BIT - 1){1'b0}},
		o_top_valid, {(ISP_TOP_VALID_BIT - ISP_TOP_LVL_LSB - ISP_PRIO_W){1'b0}}, o_top_level,
		o_top_id};

	// one select per mapped offset; an unmapped offset selects nothing and reads zero
	wire rd_sel_lines = (i_addr == ISP_OFS_LINES);
	wire rd_sel_prio_lo = (i_addr == ISP_OFS_PRIO_LO);
	wire rd_sel_prio_hi = (i_addr == ISP_OFS_PRIO_HI);
	wire rd_sel_mask_lvl = (i_addr == ISP_OFS_MASK_LVL);
	wire rd_sel_nmi_sel = (i_addr == ISP_OFS_NMI_SEL);
	wire rd_sel_pending = (i_addr == ISP_OFS_PENDING);
	wire rd_sel_top = (i_addr == ISP_OFS_TOP);
	wire rd_sel_ev_stat = (i_addr == ISP_OFS_EV_STAT);
	wire rd_sel_ev_mask = (i_addr == ISP_OFS_EV_MASK);
	wire [ISP_DATA_W-1:0] mask_lvl_word = {{(ISP_DATA_W - 3){1'b0}}, mask_lvl_q};
	wire [ISP_DATA_W-1:0] nmi_sel_word = {{(ISP_DATA_W - 6){1'b0}}, nmi_sel_q};
	wire [ISP_DATA_W-1:0] ev_stat_word = {{(ISP_DATA_W - ISP_EV_W){1'b0}}, ev_stat_q};
	wire [ISP_DATA_W-1:0] ev_mask_word = {{(ISP_DATA_W - ISP_EV_W){1'b0}}, ev_mask_q};

	assign rd_data_d = ({ISP_DATA_W{rd_sel_lines}} & o_irq_lines)
		| ({ISP_DATA_W{rd_sel_prio_lo}} & prio_lo_q)
		| ({ISP_DATA_W{rd_sel_prio_hi}} & prio_hi_q)
		| ({ISP_DATA_W{rd_sel_mask_lvl}} & mask_lvl_word)
		| ({ISP_DATA_W{rd_sel_nmi_sel}} & nmi_sel_word)
		| ({ISP_DATA_W{rd_sel_pending}} & o_irq_pending)
		| ({ISP_DATA_W{rd_sel_top}} & top_word)
		| ({ISP_DATA_W{rd_sel_ev_stat}} & ev_stat_word)
		| ({ISP_DATA_W{rd_sel_ev_mask}} & ev_mask_word);

	////////////////////////////////////////////////////////////////////////////////
	// state

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			lines_q <= '0;
		end else if (i_clk_en) begin
			lines_q <= lines_d;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_irq_pending <= '0;
		end else if (i_clk_en) begin
			o_irq_pending <= pending_d;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_top_valid <= 1'b0;
			o_top_id <= '0;
			o_top_level <= '0;
		end else if (i_clk_en) begin
			o_top_valid <= sel_valid;
			o_top_id <= sel_id;
			o_top_level <= sel_level;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_nmi <= 1'b0;
		end else if (i_clk_en) begin
			o_nmi <= nmi_d;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			prio_lo_q <= ISP_RST_PRIO;
		end else if (wr_prio_lo) begin
			prio_lo_q <= i_wr_data;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			prio_hi_q <= ISP_RST_PRIO;
		end else if (wr_prio_hi) begin
			prio_hi_q <= i_wr_data;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			mask_lvl_q <= ISP_RST_MASK_LVL;
		end else if (wr_mask_lvl) begin
			mask_lvl_q <= i_wr_data[2:0];
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			nmi_sel_q <= ISP_RST_NMI_SEL;
		end else if (wr_nmi_sel) begin
			nmi_sel_q <= i_wr_data[5:0];
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ev_mask_q <= ISP_RST_EV;
		end else if (wr_ev_mask) begin
			ev_mask_q <= i_wr_data[ISP_EV_W-1:0];
		end
	end

	// sticky events freeze with the clock enable
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ev_stat_q <= ISP_RST_EV;
		end else if (i_clk_en) begin
			ev_stat_q <= ev_stat_d;
		end
	end

	// read data stands for the one cycle after the strobe, zero otherwise
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_rd_data <= '0;
		end else if (i_clk_en) begin
			o_rd_data <= i_rd_strobe ? rd_data_d : '0;
		end
	end

	assign o_irq_lines = lines_q;
	// level interrupt stays high while an unmasked event bit is set
	assign o_irq = |(ev_stat_q & ev_mask_q);
endmodule : isp_irq_map

// >>> src/isp_pkg.sv
package isp_pkg;
	localparam int ISP_NUM_LINES = 32;
	localparam int ISP_NUM_WAKE = 12;
	localparam int ISP_PRIO_W = 2;
	localparam int ISP_ID_W = 5;
	localparam int ISP_ADDR_W = 8;
	localparam int ISP_DATA_W = 32;

	// line numbers seen by the core interrupt controller
	localparam int ISP_LINE_WAKE_FIRST = 0;
	localparam int ISP_LINE_TWOWIRE = 12;
	localparam int ISP_LINE_TIMER_FIRST = 13;
	localparam int ISP_LINE_SYNC_SERIAL = 17;
	localparam int ISP_LINE_SERIAL_FIRST = 18;
	localparam int ISP_LINE_SERIAL_SECOND = 19;
	localparam int ISP_LINE_COMPARATOR = 20;
	localparam int ISP_LINE_ADC = 21;
	localparam int ISP_LINE_WATCHDOG = 22;
	localparam int ISP_LINE_BROWNOUT = 23;
	localparam int ISP_LINE_RSVD_A = 24;
	localparam int ISP_LINE_PORT_FIRST = 25;
	localparam int ISP_LINE_RSVD_B = 28;
	localparam int ISP_LINE_DMA = 29;
	localparam int ISP_LINE_RTC = 30;
	localparam int ISP_LINE_RSVD_C = 31;

	// register byte offsets
	localparam logic [ISP_ADDR_W-1:0] ISP_OFS_LINES = 8'h00;
	localparam logic [ISP_ADDR_W-1:0] ISP_OFS_PRIO_LO = 8'h04;
	localparam logic [ISP_ADDR_W-1:0] ISP_OFS_PRIO_HI = 8'h08;
	localparam logic [ISP_ADDR_W-1:0] ISP_OFS_MASK_LVL = 8'h0C;
	localparam logic [ISP_ADDR_W-1:0] ISP_OFS_NMI_SEL = 8'h10;
	localparam logic [ISP_ADDR_W-1:0] ISP_OFS_PENDING = 8'h14;
	localparam logic [ISP_ADDR_W-1:0] ISP_OFS_TOP = 8'h18;
	localparam logic [ISP_ADDR_W-1:0] ISP_OFS_EV_STAT = 8'h1C;
	localparam logic [ISP_ADDR_W-1:0] ISP_OFS_EV_MASK = 8'h20;

	// field positions
	localparam int ISP_MASK_EN_BIT = 0;
	localparam int ISP_MASK_LVL_LSB = 1;
	localparam int ISP_NMI_EN_BIT = 5;
	localparam int ISP_TOP_VALID_BIT = 8;
	localparam int ISP_TOP_LVL_LSB = 5;
	localparam int ISP_EV_NMI_BIT = 0;
	localparam int ISP_EV_BLOCKED_BIT = 1;
	localparam int ISP_EV_W = 2;

	// reset values
	localparam logic [ISP_DATA_W-1:0] ISP_RST_PRIO = 32'h0000_0000;
	localparam logic [2:0] ISP_RST_MASK_LVL = 3'h0;
	localparam logic [5:0] ISP_RST_NMI_SEL = 6'h00;
	localparam logic [ISP_EV_W-1:0] ISP_RST_EV = 2'h0;
endpackage : isp_pkg

// >>> src/isp_prio_sel.sv
module isp_prio_sel
	import isp_pkg::*;
#(
	parameter int N = ISP_NUM_LINES,
	parameter int PW = ISP_PRIO_W,
	parameter int IW = $clog2(N)
) (
	input wire logic [N-1:0] i_req,
	input wire logic [N*PW-1:0] i_prio,
	output logic o_valid,
	output logic [IW-1:0] o_id,
	output logic [PW-1:0] o_level
);
	if (N < 2 || IW != $clog2(N)) begin : g_bad_size
		$error("isp_prio_sel: bad N or IW");
	end

	logic [PW-1:0] lvl [N];

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_lvl
			assign lvl[g] = i_prio[g*PW +: PW];
		end
	endgenerate

	// lowest level value wins, lower line number breaks a tie
	always_comb begin
		o_valid = 1'b0;
		o_id = '0;
		o_level = '0;
		for (int k = 0; k < N; k++) begin
			if (i_req[k] && (!o_valid || lvl[k] < o_level)) begin
				o_valid = 1'b1;
				o_id = IW'(k);
				o_level = lvl[k];
			end
		end
	end
endmodule : isp_prio_sel

// >>> dv/isp_irq_map_assertions.sv
module isp_irq_map_chk
	import isp_pkg::*;
#(
	parameter int NUM_LINES = ISP_NUM_LINES,
	parameter int NUM_WAKE = ISP_NUM_WAKE
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_clk_en,
	input wire logic [NUM_WAKE-1:0] i_wakeup_pins,
	input wire logic i_twowire_state_flag,
	input wire logic [6:0] i_serial_port_first_flags,
	input wire logic i_watchdog_unit_flag,
	input wire logic i_brownout_detector_flag,
	input wire logic [2:0] i_port_pin_flags,
	input wire logic i_dma_flag,
	input wire logic i_rtc_flag,
	input wire logic [NUM_LINES-1:0] o_irq_lines,
	input wire logic [NUM_LINES-1:0] o_irq_pending
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	chk_wake_lines: assert property (
		i_clk_en |=> o_irq_lines[NUM_WAKE-1:0] == $past(i_wakeup_pins)) else $error("wake lines");
	chk_reserved_low: assert property (
		!o_irq_lines[24] && !o_irq_lines[28] && !o_irq_lines[31]) else $error("reserved line");
	chk_twowire_line: assert property (
		i_clk_en |=> o_irq_lines[12] == $past(i_twowire_state_flag)) else $error("line 12");
	chk_serial_merge: assert property (
		i_clk_en |=> o_irq_lines[18] == |$past(i_serial_port_first_flags)) else $error("line 18");
	chk_late_lines: assert property (
		i_clk_en |=> o_irq_lines[23:22] == $past({i_brownout_detector_flag, i_watchdog_unit_flag}))
		else $error("lines 22 23");
	chk_port_lines: assert property (
		i_clk_en |=> o_irq_lines[30:29] == $past({i_rtc_flag, i_dma_flag})
		&& o_irq_lines[27:25] == $past(i_port_pin_flags)) else $error("lines 25 to 30");
	chk_pending_subset: assert property (
		(o_irq_pending & ~o_irq_lines) == '0) else $error("pending without line");
	chk_freeze_hold: assert property (
		!i_clk_en |=> $stable(o_irq_lines) && $stable(o_irq_pending)) else $error("moved while frozen");
endmodule : isp_irq_map_chk

bind isp_irq_map isp_irq_map_chk #(.NUM_LINES(NUM_LINES), .NUM_WAKE(NUM_WAKE)) isp_irq_map_chk_inst (.*);

// >>> dv/isp_core_model.sv
module isp_core_model
	import isp_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_nmi,
	input wire logic i_top_valid,
	input wire logic [ISP_ID_W-1:0] i_top_id,
	output logic [7:0] o_nmi_count,
	output logic [ISP_ID_W-1:0] o_taken_id
);
	timeunit 1ns;
	timeprecision 1ps;
	logic nmi_q;
	// counts nmi entries and remembers the last request it would take
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			nmi_q <= 1'h0;
			o_nmi_count <= 8'h00;
			o_taken_id <= '0;
		end else begin
			nmi_q <= i_nmi;
			if (i_nmi && !nmi_q) begin
				o_nmi_count <= o_nmi_count + 8'h01;
			end
			if (i_top_valid) begin
				o_taken_id <= i_top_id;
			end
		end
	end
endmodule : isp_core_model

// >>> dv/isp_irq_map_tb.sv
module isp_irq_map_tb;
	import isp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'h0;
	logic i_rst = 1'h1;
	logic en = 1'h1;
	logic wstb = 1'h0;
	logic rstb = 1'h0;
	logic [7:0] addr = '0;
	logic [31:0] wdata = '0;
	logic [71:0] fl = '0;
	logic [31:0] rdata, lines, pend;
	logic tv, nmi, irq;
	logic [4:0] tid, taken;
	logic [1:0] tlv;
	logic [7:0] nmi_cnt;
	int fail_count = 0;
	int n_tests = 0;
	always #2.5 i_clock = ~i_clock;
	isp_irq_map isp_irq_map_inst (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(en),
		.i_wakeup_pins(fl[11:0]), .i_twowire_state_flag(fl[12]), .i_short_timer_a_flags(fl[20:13]),
		.i_short_timer_b_flags(fl[28:21]), .i_long_timer_a_flags(fl[36:29]),
		.i_long_timer_b_flags(fl[44:37]), .i_sync_serial_port_flags(fl[48:45]),
		.i_serial_port_first_flags(fl[55:49]), .i_serial_port_second_flags(fl[61:56]),
		.i_comparator_flags(fl[63:62]), .i_adc_done_flag(fl[64]), .i_watchdog_unit_flag(fl[65]),
		.i_brownout_detector_flag(fl[66]), .i_port_pin_flags(fl[69:67]), .i_dma_flag(fl[70]),
		.i_rtc_flag(fl[71]), .i_addr(addr), .i_wr_data(wdata), .i_wr_strobe(wstb),
		.i_rd_strobe(rstb), .o_rd_data(rdata), .o_irq_lines(lines), .o_irq_pending(pend),
		.o_top_valid(tv), .o_top_id(tid), .o_top_level(tlv), .o_nmi(nmi), .o_irq(irq));
	isp_core_model isp_core_model_inst (.i_clock(i_clock), .i_rst(i_rst), .i_nmi(nmi),
		.i_top_valid(tv), .i_top_id(tid), .o_nmi_count(nmi_cnt), .o_taken_id(taken));
	////////////////////////////////////////////////////////////////////////////////
	function automatic int line_of(input int b);
		if (b < 13) return b;
		if (b < 45) return 13 + (b - 13) / 8;
		if (b < 49) return 17;
		if (b < 56) return 18;
		if (b < 62) return 19;
		if (b < 64) return 20;
		if (b < 67) return b - 43;
		if (b < 70) return b - 42;
		return b - 41;
	endfunction : line_of
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		addr <= a;
		wdata <= d;
		wstb <= 1'h1;
		@(posedge i_clock);
		wstb <= 1'h0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_clock);
		addr <= a;
		rstb <= 1'h1;
		@(posedge i_clock);
		rstb <= 1'h0;
		#1;
		chk("rd_data", e, rdata);
	endtask : rd
	task flags(input logic [71:0] v, input int n);
		@(posedge i_clock);
		fl <= v;
		repeat (n) @(posedge i_clock);
		#1;
	endtask : flags
	////////////////////////////////////////////////////////////////////////////////
	task t_map;
		for (int b = 0; b < 72; b++) begin
			flags(72'h1 << b, 1);
			chk("irq_lines", 32'h1 << line_of(b), lines);
		end
		flags('1, 1);
		chk("irq_lines", 32'h6EFF_FFFF, lines);
		@(posedge i_clock);
		en <= 1'h0;
		fl <= '0;
		repeat (2) @(posedge i_clock);
		#1;
		chk("frozen", 32'h6EFF_FFFF, lines);
		@(posedge i_clock);
		en <= 1'h1;
	endtask : t_map
	task t_prio;
		wr(ISP_OFS_PRIO_LO, 32'h0000_0040);
		rd(ISP_OFS_PRIO_LO, 32'h0000_0040);
		flags((72'h1 << 62) | 72'h8, 2);
		chk("top_id", 32'h0000_0014, {27'h0, tid});
		chk("top_level", 32'h0, {30'h0, tlv});
		chk("taken", 32'h0000_0014, {27'h0, taken});
		rd(ISP_OFS_TOP, 32'h0000_0114);
		@(posedge i_clock);
		#1;
		chk("rd_idle", 32'h0, rdata);
		rd(ISP_OFS_LINES, 32'h0010_0008);
		wr(ISP_OFS_MASK_LVL, 32'h0000_0003);
		flags(fl, 2);
		chk("pending", 32'h0010_0000, pend);
		rd(ISP_OFS_PENDING, 32'h0010_0000);
		rd(ISP_OFS_MASK_LVL, 32'h0000_0003);
		wr(ISP_OFS_MASK_LVL, 32'h0000_0001);
		flags(fl, 2);
		chk("pending", 32'h0, pend);
		chk("top_valid", 32'h0, {31'h0, tv});
		flags(fl | 72'h1, 2);
		rd(ISP_OFS_EV_STAT, 32'h0000_0002);
		wr(ISP_OFS_EV_STAT, 32'h0000_0002);
		rd(ISP_OFS_EV_STAT, 32'h0);
		wr(ISP_OFS_MASK_LVL, 32'h0);
		wr(ISP_OFS_PRIO_HI, 32'h0000_0300);
		flags((72'h1 << 62) | 72'h8, 2);
		chk("top_id", 32'h0000_0003, {27'h0, tid});
		chk("top_level", 32'h0000_0001, {30'h0, tlv});
		flags('0, 1);
	endtask : t_prio
	task t_nmi;
		wr(ISP_OFS_EV_MASK, 32'h0000_0001);
		rd(ISP_OFS_EV_MASK, 32'h0000_0001);
		for (int k = 0; k < 2; k++) begin
			wr(ISP_OFS_NMI_SEL, k ? 32'h0000_003E : 32'h0000_0032);
			flags(72'h1 << (k ? 71 : 49), 2);
			chk("nmi", 32'h1, {31'h0, nmi});
			chk("irq", 32'h1, {31'h0, irq});
			flags(72'h1 << 56, 1);
			chk("nmi", 32'h0, {31'h0, nmi});
			wr(ISP_OFS_EV_STAT, 32'h0000_0001);
			rd(ISP_OFS_EV_STAT, 32'h0);
			chk("irq", 32'h0, {31'h0, irq});
		end
		rd(ISP_OFS_NMI_SEL, 32'h0000_003E);
		flags('0, 1);
		wr(ISP_OFS_EV_MASK, 32'h0);
		flags(72'h1 << 71, 2);
		chk("irq", 32'h0, {31'h0, irq});
		rd(ISP_OFS_EV_STAT, 32'h0000_0001);
		chk("nmi_count", 32'h0000_0003, {24'h0, nmi_cnt});
		flags('0, 1);
	endtask : t_nmi
	task summarize;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (2) @(posedge i_clock);
		i_rst <= 1'h0;
		t_map();
		t_prio();
		t_nmi();
		rd(8'h40, 32'h0);
		summarize();
	end
	initial begin
		#20000;
		fail_count++;
		summarize();
	end
endmodule : isp_irq_map_tb
